// file: verilog/serial_peripheral_control.sv
/*
 * Serial peripheral port: control word, data and status over Avalon-MM,
 * master shifter on clk, slave shifter on the partner's serial clock.
 * Assumes an Avalon-MM master that holds its request until waitrequest is
 * low, and pin pads that resolve the output enables.
 */
// Implementation choices: the register offsets and the Avalon-MM interface to the registers.
// Overview of operation
// - clock-disable set stops driving the serial clock pin; clear drives it while the port is enabled as master.
// - data-out disable set releases the data-out pin; clear lets the port drive it.
// - width select set gives 16-bit transfers, clear gives 8-bit transfers.
// - master samples input at end of bit time when set, middle when clear.
// - edge select clear: output changes idle-to-active; set: active-to-idle.
`default_nettype none

`include "serial_peripheral_consts.svh"

module serial_peripheral_control
    import serial_peripheral_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic [3:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output wire logic [31:0] readdata,
    output wire logic        waitrequest,
    input  wire logic        serialClockPinIn,
    output wire logic        serialClockPinOut,
    output wire logic        serialClockPinOe,
    output wire logic        serialDataOutPin,
    output wire logic        serialDataOutPinOe,
    input  wire logic        serialDataIn,
    input  wire logic        slaveSelectPinN
);

    ctl_word_t     ctlR;
    master_state_e stateR;
    master_state_e stateNxt;
    logic          enableR;
    logic          rxReadyR;
    logic          collideR;
    logic          waitReqR;
    logic          doneSeenR;
    logic [31:0]   rdataR;
    logic [15:0]   txBufR;
    logic [15:0]   rxDataR;
    logic [15:0]   shiftR;
    logic [15:0]   rxShiftR;
    logic [9:0]    divCntR;
    logic [4:0]    bitIdxR;
    logic          sclkR;
    logic          sdoR;
    logic          sclkOeR;
    logic          sdoOeR;
    wire  [2:0]    syncd;
    wire  [15:0]   linkRxWord;
    wire           linkDoneTog;
    wire           linkSdo;

    //////////////////////////////////////////////////////////////////////////
    // control fields and divider

    function automatic logic [6:0] primaryRatio(input logic [1:0] code);
        primaryRatio = `PRI_UNIT << {`PRI_TOP_CODE - code, 1'b0};
    endfunction

    function automatic logic [3:0] secondaryRatio(input logic [2:0] code);
        secondaryRatio = `SEC_TOP - {1'b0, code};
    endfunction

    function automatic logic [4:0] lastBitOf(input logic wordSel);
        lastBitOf = wordSel ? `LAST_BIT_WORD : `LAST_BIT_BYTE;
    endfunction

    wire       clkDis  = ctlR[`CTL_CLK_DIS];
    wire       sdoDis  = ctlR[`CTL_SDO_DIS];
    wire       wordSel = ctlR[`CTL_WORD];
    wire       smpEnd  = ctlR[`CTL_SMP_END];
    wire       cke     = ctlR[`CTL_CKE];
    wire       slave_select_enable    = ctlR[`CTL_SLAVE_SELECT_ENABLE];
    wire       clock_polarity_select     = ctlR[`CTL_CKP];
    wire       master  = ctlR[`CTL_MASTER];
    wire [2:0] secondary_prescale    = ctlR[`CTL_SECONDARY_PRESCALE_LSB +: 3];
    wire [1:0] primary_prescale    = ctlR[`CTL_PRIMARY_PRESCALE_LSB +: 2];

    wire       sdiSync  = syncd[0];
    wire       ssnSync  = syncd[1];
    wire       doneSync = syncd[2];

    wire [9:0] ratioRaw = {3'h0, primaryRatio(primary_prescale)} * {6'h00, secondaryRatio(secondary_prescale)};
    // a forbidden 1:1 pair would leave no room for two edges; run it at 2
    wire [9:0] ratioEff = (ratioRaw < `RATIO_MIN) ? `RATIO_MIN : ratioRaw;
    wire [9:0] halfCnt  = {1'b0, ratioEff[9:1]};
    wire       inShift  = stateR == ST_SHIFT;
    wire       atMid    = divCntR == halfCnt;
    wire       atEnd    = divCntR == ratioEff - 10'h001;
    wire       lastBit  = bitIdxR == lastBitOf(wordSel);
    wire       sampleEv = inShift & (smpEnd ? atEnd : atMid);
    wire       sclkActive = cke ? (divCntR >= halfCnt) : (divCntR < halfCnt);

    wire [15:0] rxNext  = {rxShiftR[14:0], sdiSync};
    wire [15:0] rxFinal = smpEnd ? rxNext : rxShiftR;
    wire [15:0] rxWidth = wordSel ? rxFinal : {8'h00, rxFinal[7:0]};

    //////////////////////////////////////////////////////////////////////////
    // bus decode

    wire busTake   = (read | write) & waitReqR;
    wire wrCommit  = write & ~waitReqR;
    wire rdCommit  = read & ~waitReqR;
    wire selCtl    = address == `OFS_CONTROL;
    wire selData   = address == `OFS_DATA;
    wire selStat   = address == `OFS_STATUS;

    wire slaveFrame = enableR & ~master & slave_select_enable & ~ssnSync;
    wire busy       = inShift | slaveFrame;
    wire dataWrite  = wrCommit & selData & (|byteenable[1:0]);
    wire txRefused  = dataWrite & busy;
    wire startFrame = dataWrite & ~busy & enableR & master;

    wire rxSlaveDone  = doneSync != doneSeenR;
    wire rxMasterDone = inShift & atEnd & lastBit;
    wire rxSet        = rxSlaveDone | rxMasterDone;
    wire rxClr        = rdCommit & selData;
    wire colClr       = wrCommit & selStat & byteenable[0] & writedata[`STA_COLLIDE];

    wire [15:0] ctlMerge = {byteenable[1] ? writedata[15:8] : ctlR[15:8],
                            byteenable[0] ? writedata[7:0]  : ctlR[7:0]};
    wire [15:0] txMerge  = {byteenable[1] ? writedata[15:8] : txBufR[15:8],
                            byteenable[0] ? writedata[7:0]  : txBufR[7:0]};
    wire [31:0] statWord = {28'h0000000, collideR, rxReadyR, busy, enableR};
    wire [31:0] rdMux    = selCtl  ? {16'h0000, ctlR & `CTL_MASK} :
                           selData ? {16'h0000, rxDataR} :
                           selStat ? statWord : 32'h00000000;

    // one wait cycle per request, then the answer edge
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            waitReqR <= 1'b1;
            rdataR   <= 32'h00000000;
        end else begin
            waitReqR <= ~busTake;
            if (busTake && read) begin
                rdataR <= rdMux;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            ctlR <= `CTL_RESET;
        end else if (wrCommit && selCtl) begin
            ctlR <= ctlMerge & `CTL_MASK;
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            enableR   <= 1'b0;
            rxReadyR  <= 1'b0;
            collideR  <= 1'b0;
            doneSeenR <= 1'b0;
            txBufR    <= 16'h0000;
            rxDataR   <= 16'h0000;
        end else begin
            if (wrCommit && selStat && byteenable[0]) begin
                enableR <= writedata[`STA_ENABLE];
            end
            rxReadyR  <= rxSet | (rxReadyR & ~rxClr);
            collideR  <= txRefused | (collideR & ~colClr);
            doneSeenR <= doneSync;
            if (dataWrite && !busy) begin
                txBufR <= txMerge;
            end
            if (rxMasterDone) begin
                rxDataR <= rxWidth;
            end else if (rxSlaveDone) begin
                rxDataR <= linkRxWord;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // master shifter

    always_comb begin
        stateNxt = stateR;
        case (stateR)
            ST_IDLE:  if (startFrame) stateNxt = ST_SHIFT;
            ST_SHIFT: if (!master || !enableR || rxMasterDone) stateNxt = ST_IDLE;
            default:  stateNxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stateR <= ST_IDLE;
        end else begin
            stateR <= stateNxt;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            divCntR  <= 10'h000;
            bitIdxR  <= 5'h00;
            shiftR   <= 16'h0000;
            rxShiftR <= 16'h0000;
        end else if (startFrame) begin
            divCntR  <= 10'h000;
            bitIdxR  <= 5'h00;
            shiftR   <= wordSel ? txMerge : {txMerge[7:0], 8'h00};
            rxShiftR <= 16'h0000;
        end else if (inShift) begin
            divCntR <= atEnd ? 10'h000 : divCntR + 10'h001;
            if (sampleEv) begin
                rxShiftR <= rxNext;
            end
            if (atEnd) begin
                bitIdxR <= bitIdxR + 5'h01;
                shiftR  <= {shiftR[14:0], 1'b0};
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // pins

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sclkR   <= 1'b0;
            sdoR    <= 1'b0;
            sclkOeR <= 1'b0;
            sdoOeR  <= 1'b0;
        end else begin
            sclkR   <= inShift ? (sclkActive ^ clock_polarity_select) : clock_polarity_select;
            sdoR    <= inShift ? shiftR[15] : sdoR;
            sclkOeR <= enableR & master & ~clkDis;
            sdoOeR  <= enableR & ~sdoDis & (master | ~slave_select_enable | ~ssnSync);
        end
    end

    // slave data leaves from the link domain: its sdoR flop, or txWord directly before the first output edge
    assign serialClockPinOut  = sclkR;
    assign serialClockPinOe   = sclkOeR;
    assign serialDataOutPin   = master ? sdoR : linkSdo;
    assign serialDataOutPinOe = sdoOeR;
    assign readdata           = rdataR;
    assign waitrequest        = waitReqR;

    //////////////////////////////////////////////////////////////////////////
    // crossings and slave link

    serial_pin_sync #(.WIDTH(3), .INIT(`SYNC_INIT)) u_sync (
        .clk    (clk),
        .resetn (resetn),
        .async  ({linkDoneTog, slaveSelectPinN, serialDataIn}),
        .stable (syncd)
    );

    // txBufR is only written between slave frames while slave select is enabled, so it is still here
    serial_slave_link u_link (
        .linkClk  (serialClockPinIn),
        .linkRstn (resetn & enableR & ~master & ~(slave_select_enable & slaveSelectPinN)),
        .resetn   (resetn),
        .cke      (cke),
        .clock_polarity_select      (clock_polarity_select),
        .wordSel  (wordSel),
        .txWord   (txBufR),
        .sdi      (serialDataIn),
        .sdo      (linkSdo),
        .rxWord   (linkRxWord),
        .doneTog  (linkDoneTog)
    );

    //////////////////////////////////////////////////////////////////////////
    // checks

    logic [10:0] gapR;
    logic        gapValidR;
    wire         toActive = inShift & (sclkActive ^ clock_polarity_select ^ sclkR) & sclkActive;
    logic [4:0]  samplesR;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gapR      <= 11'h000;
            gapValidR <= 1'b0;
            samplesR  <= 5'h00;
        end else begin
            gapR      <= toActive ? 11'h001 : gapR + 11'h001;
            gapValidR <= inShift & (gapValidR | toActive);
            samplesR  <= startFrame ? 5'h00 : samplesR + {4'h0, sampleEv};
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    chk_clock_disable: assert property (
        clkDis |=> !serialClockPinOe)
        else $error("clock pin driven while disabled");

    chk_data_disable: assert property (
        sdoDis |=> !serialDataOutPinOe)
        else $error("data pin driven while disabled");

    chk_frame_bits: assert property (
        rxMasterDone && !smpEnd |=> samplesR == {4'h0, 1'b1} + lastBitOf(wordSel))
        else $error("master frame sample count wrong");

    chk_mid_sample: assert property (
        sampleEv && !smpEnd && $stable(ctlR) |=> sclkR == (cke ^ clock_polarity_select))
        else $error("middle sample not on the capture edge");

    chk_end_sample: assert property (
        sampleEv && smpEnd && !rxMasterDone && $stable(ctlR) |=> divCntR == 10'h000)
        else $error("end sample not at bit boundary");

    chk_change_edge: assert property (
        inShift && $past(inShift) && $changed(sdoR) && !(cke && bitIdxR == 5'h00)
        |-> $changed(sclkR) && ((sclkR ^ clock_polarity_select) == !cke))
        else $error("data changed on the wrong clock edge");

    chk_select_gate: assert property (
        !master && slave_select_enable && ssnSync && $stable(ctlR) |=> !serialDataOutPinOe)
        else $error("slave drives data while deselected");

    chk_idle_level: assert property (
        !inShift && $past(!inShift) && $stable(ctlR) |=> serialClockPinOut == $past(clock_polarity_select))
        else $error("serial clock not at idle level");

    chk_master_role: assert property (
        !master |=> !inShift && !serialClockPinOe)
        else $error("master activity in slave role");

    chk_clock_ratio: assert property (
        toActive && gapValidR && $stable(ctlR) |-> gapR == {1'b0, ratioEff})
        else $error("serial clock period differs from divider ratio");

endmodule

`default_nettype wire

// file: verilog/serial_peripheral_consts.svh
/*
 * Register offsets, field positions, reset values and divider constants of
 * the serial peripheral control block.
 * Assumes inclusion by bare name from files under verilog/.
 */
`ifndef SERIAL_PERIPHERAL_CONSTS_SVH
`define SERIAL_PERIPHERAL_CONSTS_SVH

// byte offsets on the register bus
`define OFS_CONTROL    4'h0
`define OFS_DATA       4'h4
`define OFS_STATUS     4'h8

// control word fields
`define CTL_CLK_DIS    12
`define CTL_SDO_DIS    11
`define CTL_WORD       10
`define CTL_SMP_END    9
`define CTL_CKE        8
`define CTL_SLAVE_SELECT_ENABLE       7
`define CTL_CKP        6
`define CTL_MASTER     5
`define CTL_SECONDARY_PRESCALE_LSB   2
`define CTL_PRIMARY_PRESCALE_LSB   0
`define CTL_MASK       16'h1fff
`define CTL_RESET      16'h0000

// status word fields
`define STA_ENABLE     0
`define STA_BUSY       1
`define STA_RX_READY   2
`define STA_COLLIDE    3

// frame lengths, as index of the last bit
`define LAST_BIT_BYTE  5'h07
`define LAST_BIT_WORD  5'h0f

// divider
`define PRI_UNIT       7'h01
`define PRI_TOP_CODE   2'h3
`define SEC_TOP        4'h8
`define RATIO_MIN      10'h002

// synchroniser reset levels: done toggle, slave select (idle high), data in
`define SYNC_INIT      3'h2

`endif

// file: verilog/serial_peripheral_pkg.sv
/*
 * Types shared by the serial peripheral control block.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
`default_nettype none

package serial_peripheral_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_SHIFT = 2'b10
    } master_state_e;

    typedef logic [15:0] ctl_word_t;

endpackage

`default_nettype wire

// file: verilog/serial_pin_sync.sv
/*
 * Three-stage synchroniser for a group of independent single-bit levels.
 * Assumes each bit is a level or a toggle from outside the clk domain.
 */
`default_nettype none

module serial_pin_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT  = '0
) (
    input  wire logic             clk,
    input  wire logic             resetn,
    input  wire logic [WIDTH-1:0] async,
    output wire logic [WIDTH-1:0] stable
);

    genvar i;
    for (i = 0; i < WIDTH; i++) begin : g_bit
        logic s1R;
        logic s2R;
        logic s3R;
        logic outR;

        // the output only moves once stages two and three agree
        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                s1R  <= INIT[i];
                s2R  <= INIT[i];
                s3R  <= INIT[i];
                outR <= INIT[i];
            end else begin
                s1R <= async[i];
                s2R <= s1R;
                s3R <= s2R;
                if (s2R == s3R) begin
                    outR <= s3R;
                end
            end
        end

        assign stable[i] = outR;
    end

endmodule

`default_nettype wire

// file: verilog/serial_slave_link.sv
/*
 * Slave-role shifter, clocked by the serial clock that the partner drives.
 * Assumes cke, ckp, wordSel and txWord stay still while a frame runs, and
 * that linkRstn is held low outside frames (or while the port is master).
 */
`default_nettype none

`include "serial_peripheral_consts.svh"

module serial_slave_link (
    input  wire logic        linkClk,
    input  wire logic        linkRstn,
    input  wire logic        resetn,
    input  wire logic        cke,
    input  wire logic        clock_polarity_select,
    input  wire logic        wordSel,
    input  wire logic [15:0] txWord,
    input  wire logic        sdi,
    output wire logic        sdo,
    output wire logic [15:0] rxWord,
    output wire logic        doneTog
);

    logic [4:0]  cntR;
    logic [15:0] shR;
    logic [15:0] rxWordR;
    logic        togR;
    logic        sdoR;
    logic        outUsedR;

    // capture edge is the one opposite the output-change edge
    wire        sampleRising = cke ^ clock_polarity_select;
    wire        sampleClk    = linkClk ~^ sampleRising;
    wire [4:0]  lastIdx      = wordSel ? `LAST_BIT_WORD : `LAST_BIT_BYTE;
    wire [4:0]  outIdx       = lastIdx - cntR;
    wire [15:0] shNext       = {shR[14:0], sdi};
    wire        wordEnd      = cntR == lastIdx;

    always_ff @(posedge sampleClk or negedge linkRstn) begin
        if (!linkRstn) begin
            cntR <= 5'h00;
            shR  <= 16'h0000;
        end else begin
            shR  <= shNext;
            cntR <= wordEnd ? 5'h00 : cntR + 5'h01;
        end
    end

    // kept on the system reset so a frame end cannot fake a toggle
    always_ff @(posedge sampleClk or negedge resetn) begin
        if (!resetn) begin
            rxWordR <= 16'h0000;
            togR    <= 1'b0;
        end else if (linkRstn && wordEnd) begin
            rxWordR <= wordSel ? shNext : {8'h00, shNext[7:0]};
            togR    <= ~togR;
        end
    end

    always_ff @(negedge sampleClk or negedge linkRstn) begin
        if (!linkRstn) begin
            sdoR     <= 1'b0;
            outUsedR <= 1'b0;
        end else begin
            sdoR     <= txWord[outIdx[3:0]];
            outUsedR <= 1'b1;
        end
    end

    // first bit stands on the pin before the first clock edge
    assign sdo     = outUsedR ? sdoR : txWord[lastIdx[3:0]];
    assign rxWord  = rxWordR;
    assign doneTog = togR;

endmodule

`default_nettype wire

// file: verification/serial_partner.sv
/*
 * Far-side serial device: slave while the port is master, master with a
 * 12 ns clock, running only inside frames, while the port is slave.
 * Assumes the bench resolves the clock pin and supplies ckp and cke.
 */
`default_nettype none

module serial_partner (
    input  wire logic clock_polarity_select,
    input  wire logic cke,
    input  wire logic sckLine,
    input  wire logic sdo,
    input  wire logic sdoOe,
    output var  logic sckDrive,
    output var  logic sdi
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [15:0] txSh;
    logic [15:0] rxSh;
    logic        lastSdo;
    logic        lead;
    int          caps;
    int          nBits;

    initial begin
        sckDrive = 1'b0;
        sdi = 1'b0;
        lastSdo = 1'b0;
        caps = 0;
        nBits = 0;
    end

    ////////////////////////////////////////////////////////////////////////
    // clock idles at ckp; edges caused by the idle change are flushed first
    task automatic arm(input logic [15:0] w, input int n);
        sckDrive = clock_polarity_select;
        // the port's own clock pin settles one clk cycle after a control write
        #60;
        txSh = w << (16 - n);
        rxSh = 16'h0000;
        nBits = n;
        caps = 0;
        sdi = txSh[15];
    endtask

    task automatic runClock(input int n);
        repeat (2 * n) begin
            #6 sckDrive = ~sckDrive;
        end
    endtask

    ////////////////////////////////////////////////////////////////////////
    // capture on the edge opposite to the one where the port changes data
    always @(sckLine) begin
        lead = (sckLine != clock_polarity_select);
        if (lead == cke) begin
            rxSh = {rxSh[14:0], sdoOe ? sdo : ~lastSdo};
            caps++;
        end else if (caps > 0) begin
            txSh = txSh << 1;
            // after the last bit the line is released and keeps no value
            sdi = (caps < nBits) ? txSh[15] : ~sdi;
        end
    end

    always @(sdo or sdoOe) begin
        if (sdoOe) lastSdo = sdo;
    end

endmodule

`default_nettype wire

// file: verification/serial_peripheral_control_tb.sv
/*
 * Self-checking bench: registers over Avalon-MM, master and slave frames.
 * Assumes the design files and serial_partner.sv are compiled first.
 */
`default_nettype none

`include "serial_peripheral_consts.svh"

module serial_peripheral_control_tb
    import serial_peripheral_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [3:0]  address = 4'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic [31:0] readdata;
    logic        waitrequest;
    logic        sckOut;
    logic        sckOe;
    logic        sdoPin;
    logic        sdoOe;
    logic        sckDrive;
    logic        sdi;
    logic        ssN = 1'b1;
    logic        ckpNow = 1'b0;
    logic        ckeNow = 1'b0;
    wire  logic  sckLine = sckOe ? sckOut : sckDrive;
    int          mismatches = 0;
    int          num_checks = 0;
    int          cycles = 0;
    int          actCnt = 0;

    always #12.5 clk = ~clk;

    serial_peripheral_control DUT (
        .clk                (clk),
        .resetn             (resetn),
        .address            (address),
        .read               (read),
        .write              (write),
        .writedata          (writedata),
        .byteenable         (4'hf),
        .readdata           (readdata),
        .waitrequest        (waitrequest),
        .serialClockPinIn   (sckLine),
        .serialClockPinOut  (sckOut),
        .serialClockPinOe   (sckOe),
        .serialDataOutPin   (sdoPin),
        .serialDataOutPinOe (sdoOe),
        .serialDataIn       (sdi),
        .slaveSelectPinN    (ssN)
    );

    serial_partner P (
        .clock_polarity_select      (ckpNow),
        .cke      (ckeNow),
        .sckLine  (sckLine),
        .sdo      (sdoPin),
        .sdoOe    (sdoOe),
        .sckDrive (sckDrive),
        .sdi      (sdi)
    );

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clk) begin
        cycles++;
        if (sckOe === 1'b1 && sckOut !== ckpNow) actCnt++;
        if (cycles == 40000) begin
            mismatches++;
            conclude();
        end
    end

    task automatic conclude();
        if (mismatches == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int t;
        t = 0;
        @(posedge clk);
        address   <= a;
        writedata <= d;
        write     <= wr;
        read      <= ~wr;
        do begin
            @(posedge clk);
            t++;
        end while (waitrequest !== 1'b0 && t < 50);
        if (waitrequest !== 1'b0) mismatches++;
        q = readdata;
        write <= 1'b0;
        read  <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // one random frame; ratios of 12 or more keep the input sync lag harmless
    task automatic frame(input logic mst);
        ctl_word_t   ctl;
        logic [15:0] tx;
        logic [15:0] px;
        logic [15:0] mask;
        logic [31:0] q;
        int          n;
        int          r;
        int          t;
        int          c0;
        ctl = 16'h0000;
        ctl[`CTL_CKE] = 1'($urandom);
        ctl[`CTL_CKP] = 1'($urandom);
        ctl[`CTL_WORD] = 1'($urandom);
        ctl[`CTL_MASTER] = mst;
        ctl[`CTL_SLAVE_SELECT_ENABLE] = ~mst;
        ctl[`CTL_SMP_END] = mst & 1'($urandom);
        ctl[`CTL_PRIMARY_PRESCALE_LSB +: 2] = ($urandom % 2) ? 2'h1 : 2'h2;
        ctl[`CTL_SECONDARY_PRESCALE_LSB +: 3] = 3'($urandom % 6);
        r = (ctl[1:0] == 2'h1 ? 16 : 4) * (8 - int'(ctl[4:2]));
        n = ctl[`CTL_WORD] ? 16 : 8;
        mask = ctl[`CTL_WORD] ? 16'hffff : 16'h00ff;
        tx = 16'($urandom);
        px = 16'($urandom);
        bus(1'b1, `OFS_CONTROL, {16'h0000, ctl}, q);
        ckpNow = ctl[`CTL_CKP];
        ckeNow = ctl[`CTL_CKE];
        P.arm(px, n);
        c0 = actCnt;
        bus(1'b1, `OFS_DATA, {16'h0000, tx}, q);
        if (mst) begin
            bus(1'b1, `OFS_DATA, 32'h0000_0000, q);
            t = 0;
            do begin
                bus(1'b0, `OFS_STATUS, 32'h0, q);
                t++;
            end while (q[`STA_RX_READY] !== 1'b1 && t < 3000);
            check(q[`STA_COLLIDE], 1'b1);
            check(32'(actCnt - c0), 32'(n * r / 2));
        end else begin
            ssN <= 1'b0;
            // select must pass the pin sync before the data pin is driven
            repeat (6) @(posedge clk);
            P.runClock(n);
            repeat (10) @(posedge clk);
            ssN <= 1'b1;
            bus(1'b0, `OFS_STATUS, 32'h0, q);
            check(q[`STA_RX_READY], 1'b1);
        end
        bus(1'b0, `OFS_DATA, 32'h0, q);
        check(q, {16'h0000, px & mask});
        check({16'h0000, P.rxSh & mask}, {16'h0000, tx & mask});
        bus(1'b1, `OFS_STATUS, 32'h9, q);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] q;
        logic [31:0] w;
        void'($urandom(32'h38aee5de));
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        bus(1'b0, `OFS_CONTROL, 32'h0, q);
        check(q, {16'h0000, `CTL_RESET});
        bus(1'b0, `OFS_STATUS, 32'h0, q);
        check(q, 32'h0000_0000);
        bus(1'b1, 4'hc, 32'hffff_ffff, q);
        bus(1'b0, 4'hc, 32'h0, q);
        check(q, 32'h0000_0000);
        repeat (6) begin
            w = $urandom & 32'hffff_fdef;
            bus(1'b1, `OFS_CONTROL, w, q);
            bus(1'b0, `OFS_CONTROL, 32'h0, q);
            check(q, {16'h0000, w[15:0] & `CTL_MASK});
        end
        bus(1'b1, `OFS_STATUS, 32'h1, q);
        bus(1'b1, `OFS_CONTROL, 32'h1820, q);
        repeat (3) @(negedge clk);
        check(sckOe, 1'b0);
        check(sdoOe, 1'b0);
        bus(1'b1, `OFS_CONTROL, 32'h0060, q);
        ckpNow = 1'b1;
        repeat (3) @(negedge clk);
        check(sckOe, 1'b1);
        check(sdoOe, 1'b1);
        check(sckOut, 1'b1);
        bus(1'b1, `OFS_CONTROL, 32'h0000, q);
        repeat (3) @(negedge clk);
        check(sckOe, 1'b0);
        check(sckOut, 1'b0);
        repeat (4) frame(1'b1);
        repeat (3) frame(1'b0);
        conclude();
    end

endmodule

`default_nettype wire
